// File: design/imu_regs_pkg.sv
// Register map, field layouts, carriers and timing constants of the IMU register bank.
package imu_regs_pkg;

   // Clock and sample timing.
   localparam int CLOCK_HZ = 40_000_000;
   localparam int CLOCK_PERIOD_PS = 25_000;
   localparam int SAMPLE_RATE_MILLI_SPS = 819_200;
   localparam longint PS_PER_KILOSECOND = longint'(1_000_000_000) * longint'(1_000_000);
   localparam longint SAMPLE_PERIOD_PS = PS_PER_KILOSECOND / SAMPLE_RATE_MILLI_SPS;
   localparam int SAMPLE_PERIOD_CYCLES = int'(SAMPLE_PERIOD_PS / CLOCK_PERIOD_PS);

   // Command durations.
   localparam int FLASH_BACKUP_MS = 75;
   localparam int FLASH_BACKUP_CYCLES = FLASH_BACKUP_MS * (CLOCK_HZ / 1000);
   localparam int SOFT_RESET_US = 200;
   localparam int SOFT_RESET_CYCLES = SOFT_RESET_US * (CLOCK_HZ / 1_000_000);
   localparam int CAL_RESTORE_US = 100;
   localparam int CAL_RESTORE_CYCLES = CAL_RESTORE_US * (CLOCK_HZ / 1_000_000);
   localparam int BIAS_CORRECT_US = 100;
   localparam int BIAS_CORRECT_CYCLES = BIAS_CORRECT_US * (CLOCK_HZ / 1_000_000);
   localparam int CONFIG_RELOAD_US = 50;
   localparam int CONFIG_RELOAD_CYCLES = CONFIG_RELOAD_US * (CLOCK_HZ / 1_000_000);
   localparam int CNT_W = 22;

   // Byte addresses of the low byte of each register.
   localparam logic [6:0] ADDR_RATE_X = 7'h04;
   localparam logic [6:0] ADDR_RATE_Y = 7'h06;
   localparam logic [6:0] ADDR_RATE_Z = 7'h08;
   localparam logic [6:0] ADDR_ACCEL_X = 7'h0A;
   localparam logic [6:0] ADDR_ACCEL_Y = 7'h0C;
   localparam logic [6:0] ADDR_ACCEL_Z = 7'h0E;
   localparam logic [6:0] ADDR_TEMPERATURE = 7'h18;
   localparam logic [6:0] ADDR_SYSTEM_COMMAND = 7'h3E;
   localparam logic [6:0] ADDR_LOT_CODE_LOW = 7'h52;
   localparam logic [6:0] ADDR_LOT_CODE_HIGH = 7'h54;
   localparam logic [6:0] ADDR_PRODUCT_CODE = 7'h56;
   localparam logic [6:0] ADDR_UNIT_SERIAL = 7'h58;

   // Fields of the system command register.
   localparam int CMD_BIAS = 0;
   localparam int CMD_CAL = 1;
   localparam int CMD_FLASH = 3;
   localparam int CMD_RESET = 7;
   localparam logic [7:0] CMD_MASK = 8'h8B;
   localparam logic [7:0] CMD_RESET_VALUE = 8'h00;
   localparam logic [15:0] WORD_ZERO = 16'h0000;

   // Fields of the serial frame.
   localparam int FRAME_WRITE_BIT = 15;
   localparam int FRAME_ADDR_MSB = 14;
   localparam int FRAME_ADDR_LSB = 8;

   typedef struct packed {
      logic [15:0] rate_x;
      logic [15:0] rate_y;
      logic [15:0] rate_z;
      logic [15:0] accel_x;
      logic [15:0] accel_y;
      logic [15:0] accel_z;
      logic [11:0] temperature;
   } sensor_frame_t;

   typedef struct packed {
      logic soft_reset;
      logic cal_restore;
      logic bias_correct;
      logic flash_backup;
      logic config_reload;
   } cmd_activity_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_RESET = 3'h1,
      ST_CAL = 3'h2,
      ST_BIAS = 3'h3,
      ST_FLASH = 3'h4,
      ST_RELOAD = 3'h5
   } cmd_state_t;

endpackage : imu_regs_pkg

// File: design/spi_word_port.sv
// Serial slave port in clock mode 3 that moves one word per frame.
`timescale 1ns/1ps
`default_nettype none
module spi_word_port #(
   parameter int WIDTH = 16
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic nrst,
   // Serial pins.
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   output var logic miso,
   // Word side.
   input wire logic [WIDTH-1:0] reply,
   output var logic frame_done,
   output var logic [WIDTH-1:0] frame_word
);
   localparam int CW = $clog2(WIDTH);

   logic [2:0] meta;
   logic [2:0] pins;
   logic [2:0] pins_prev;
   logic [WIDTH-1:0] shift_in;
   logic [WIDTH-1:0] next_shift_in;
   logic [WIDTH-1:0] shift_out;
   logic [WIDTH-1:0] next_shift_out;
   logic [WIDTH-1:0] next_frame_word;
   logic [WIDTH-1:0] source;
   logic [CW-1:0] count;
   logic [CW-1:0] next_count;
   logic next_miso;
   logic next_frame_done;
   logic cs_fall;
   logic sclk_rise;
   logic sclk_fall;

   // Pins are ordered sclk, cs_n, mosi; edges are judged on synchronised copies only.
   always_comb begin
      cs_fall = pins_prev[1] && !pins[1];
      sclk_rise = !pins_prev[2] && pins[2] && !pins[1];
      sclk_fall = pins_prev[2] && !pins[2] && !pins[1];
      source = (count == '0) ? reply : shift_out;
      next_shift_in = shift_in;
      next_shift_out = shift_out;
      next_count = count;
      next_miso = miso;
      next_frame_done = 1'b0;
      next_frame_word = frame_word;
      if (cs_fall) begin
         next_count = '0;
      end else if (sclk_fall) begin
         next_miso = source[WIDTH-1];
         next_shift_out = {source[WIDTH-2:0], 1'b0};
      end
      if (sclk_rise) begin
         next_shift_in = {shift_in[WIDTH-2:0], pins[0]};
         next_count = count + 1'b1;
         if (count == CW'(WIDTH - 1)) begin
            next_frame_done = 1'b1;
            next_frame_word = {shift_in[WIDTH-2:0], pins[0]};
         end
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         meta <= 3'h6;
         pins <= 3'h6;
         pins_prev <= 3'h6;
         shift_in <= '0;
         shift_out <= '0;
         count <= '0;
         miso <= 1'b0;
         frame_done <= 1'b0;
         frame_word <= '0;
      end else begin
         meta <= {sclk, cs_n, mosi};
         pins <= meta;
         pins_prev <= pins;
         shift_in <= next_shift_in;
         shift_out <= next_shift_out;
         count <= next_count;
         miso <= next_miso;
         frame_done <= next_frame_done;
         frame_word <= next_frame_word;
      end
   end

endmodule : spi_word_port
`default_nettype wire

// File: design/sample_timer.sv
// Divider that gives a one-cycle sample enable once per sample period.
`timescale 1ns/1ps
`default_nettype none
module sample_timer #(
   parameter int PERIOD = 48_828
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic nrst,
   // Control and enable.
   input wire logic hold,
   output var logic tick
);
   localparam int TW = $clog2(PERIOD + 1);

   logic [TW-1:0] count;
   logic [TW-1:0] next_count;
   logic next_tick;

   // Holding restarts the period so the first sample after a command is a full period late.
   always_comb begin
      next_tick = 1'b0;
      next_count = count + 1'b1;
      if (hold) begin
         next_count = '0;
      end else if (count == TW'(PERIOD - 1)) begin
         next_count = '0;
         next_tick = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         count <= '0;
         tick <= 1'b0;
      end else begin
         count <= next_count;
         tick <= next_tick;
      end
   end

endmodule : sample_timer
`default_nettype wire

// File: design/imu_output_and_command_registers.sv
// Output, command and identification registers of the inertial sensor behind its serial port.
//
// Contract
// - Rate words are 16-bit twos complement, 100 counts per deg/s, zero reads zero.
// - Rate x, y, z words answer at addresses 0x04, 0x06, 0x08.
// - Acceleration words are 16-bit twos complement, 4000 counts per g.
// - Acceleration x, y, z words answer at addresses 0x0A, 0x0C, 0x0E.
// - Temperature is 12-bit twos complement in low bits; upper four bits unused.
// - Temperature word answers at address 0x18, read only.
// - System command register at 0x3E is write only and resets to zero.
// - Writing one to a command bit starts it; the bit clears when done.
// - Command bit 7 requests a software reset of the device.
// - Command bit 3 copies the user configuration into flash.
// - Control registers reload from flash before any new samples appear; after nrst, sampling starts with no reload.
// - Bit 1 restores calibration, bit 0 corrects bias; other bits do nothing.
// - Product code at 0x56 is a fixed read-only word.
// - Lot words at 0x52 and 0x54 together form a 32-bit lot code.
// - Serial number at 0x58 sits in the low 12 bits, top four zero.
// - Sampling starts unaided and refreshes outputs at 819.2 samples per second.
// - Each register is two bytes: low byte at address, high at address plus one.
// - Flash backup runs only after calibration restore and bias correction finish.
`timescale 1ns/1ps
`default_nettype none
module imu_output_and_command_registers #(
   parameter int SAMPLE_CYCLES = imu_regs_pkg::SAMPLE_PERIOD_CYCLES,
   parameter int FLASH_CYCLES = imu_regs_pkg::FLASH_BACKUP_CYCLES,
   parameter int RESET_CYCLES = imu_regs_pkg::SOFT_RESET_CYCLES,
   parameter int CAL_CYCLES = imu_regs_pkg::CAL_RESTORE_CYCLES,
   parameter int BIAS_CYCLES = imu_regs_pkg::BIAS_CORRECT_CYCLES,
   parameter int RELOAD_CYCLES = imu_regs_pkg::CONFIG_RELOAD_CYCLES,
   // Identification values below are arbitrary.
   parameter logic [15:0] PRODUCT_CODE = 16'h5A17,
   parameter logic [15:0] LOT_CODE_LOW = 16'h1357,
   parameter logic [15:0] LOT_CODE_HIGH = 16'h2468,
   parameter logic [11:0] UNIT_SERIAL = 12'h001
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic nrst,
   // Serial pins.
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   output var logic miso,
   // Sensor front end.
   input wire imu_regs_pkg::sensor_frame_t sensor_data,
   // Command activity and sample strobe.
   output var imu_regs_pkg::cmd_activity_t activity,
   output var logic sample_strobe
);
   imu_regs_pkg::cmd_state_t state;
   imu_regs_pkg::cmd_state_t next_state;
   imu_regs_pkg::sensor_frame_t outs;
   imu_regs_pkg::sensor_frame_t next_outs;
   imu_regs_pkg::cmd_activity_t next_activity;
   logic [imu_regs_pkg::CNT_W-1:0] cnt;
   logic [imu_regs_pkg::CNT_W-1:0] next_cnt;
   logic [7:0] pend;
   logic [7:0] next_pend;
   logic [7:0] cmd_set;
   logic [7:0] cmd_clear;
   logic [15:0] reply;
   logic [15:0] next_reply;
   logic [15:0] frame_word;
   logic [6:0] frame_addr;
   logic [6:0] word_addr;
   logic frame_done;
   logic frame_read;
   logic frame_write;
   logic tick;
   logic busy;
   logic next_strobe;

   spi_word_port #(
      .WIDTH(16)
   ) u_port (
      .clock(clock),
      .nrst(nrst),
      .sclk(sclk),
      .cs_n(cs_n),
      .mosi(mosi),
      .miso(miso),
      .reply(reply),
      .frame_done(frame_done),
      .frame_word(frame_word)
   );

   // Sampling runs from reset without setup and pauses while a command is busy.
   sample_timer #(
      .PERIOD(SAMPLE_CYCLES)
   ) u_timer (
      .clock(clock),
      .nrst(nrst),
      .hold(busy),
      .tick(tick)
   );

   // Frame decode and register read path.
   always_comb begin
      frame_addr = frame_word[imu_regs_pkg::FRAME_ADDR_MSB:imu_regs_pkg::FRAME_ADDR_LSB];
      word_addr = {frame_addr[6:1], 1'b0};
      frame_read = frame_done && !frame_word[imu_regs_pkg::FRAME_WRITE_BIT];
      frame_write = frame_done && frame_word[imu_regs_pkg::FRAME_WRITE_BIT];
      busy = (state != imu_regs_pkg::ST_IDLE);
      next_reply = reply;
      if (frame_done) begin
         next_reply = imu_regs_pkg::WORD_ZERO;
      end
      if (frame_read) begin
         case (word_addr)
            imu_regs_pkg::ADDR_RATE_X: next_reply = outs.rate_x;
            imu_regs_pkg::ADDR_RATE_Y: next_reply = outs.rate_y;
            imu_regs_pkg::ADDR_RATE_Z: next_reply = outs.rate_z;
            imu_regs_pkg::ADDR_ACCEL_X: next_reply = outs.accel_x;
            imu_regs_pkg::ADDR_ACCEL_Y: next_reply = outs.accel_y;
            imu_regs_pkg::ADDR_ACCEL_Z: next_reply = outs.accel_z;
            imu_regs_pkg::ADDR_TEMPERATURE: next_reply = {4'h0, outs.temperature};
            imu_regs_pkg::ADDR_LOT_CODE_LOW: next_reply = LOT_CODE_LOW;
            imu_regs_pkg::ADDR_LOT_CODE_HIGH: next_reply = LOT_CODE_HIGH;
            imu_regs_pkg::ADDR_PRODUCT_CODE: next_reply = PRODUCT_CODE;
            imu_regs_pkg::ADDR_UNIT_SERIAL: next_reply = {4'h0, UNIT_SERIAL};
            default: next_reply = imu_regs_pkg::WORD_ZERO;
         endcase
      end
   end

   // Only the low byte of the command register holds live bits.
   always_comb begin
      cmd_set = 8'h00;
      if (frame_write && frame_addr == imu_regs_pkg::ADDR_SYSTEM_COMMAND) begin
         cmd_set = frame_word[7:0] & imu_regs_pkg::CMD_MASK;
      end
   end

   // Command sequencer and atomic sample update.
   always_comb begin
      next_state = state;
      next_outs = outs;
      next_strobe = 1'b0;
      cmd_clear = 8'h00;
      next_cnt = (cnt == '0) ? cnt : cnt - 1'b1;
      case (state)
         imu_regs_pkg::ST_IDLE: begin
            if (pend[imu_regs_pkg::CMD_RESET]) begin
               next_state = imu_regs_pkg::ST_RESET;
               next_cnt = imu_regs_pkg::CNT_W'(RESET_CYCLES - 1);
            end else if (pend[imu_regs_pkg::CMD_CAL]) begin
               next_state = imu_regs_pkg::ST_CAL;
               next_cnt = imu_regs_pkg::CNT_W'(CAL_CYCLES - 1);
            end else if (pend[imu_regs_pkg::CMD_BIAS]) begin
               next_state = imu_regs_pkg::ST_BIAS;
               next_cnt = imu_regs_pkg::CNT_W'(BIAS_CYCLES - 1);
            end else if (pend[imu_regs_pkg::CMD_FLASH]) begin
               next_state = imu_regs_pkg::ST_FLASH;
               next_cnt = imu_regs_pkg::CNT_W'(FLASH_CYCLES - 1);
            end else if (tick) begin
               next_outs = sensor_data;
               next_strobe = 1'b1;
            end
         end
         imu_regs_pkg::ST_RESET: begin
            next_outs = '0;
            if (cnt == '0) begin
               cmd_clear = imu_regs_pkg::CMD_MASK;
               next_state = imu_regs_pkg::ST_RELOAD;
               next_cnt = imu_regs_pkg::CNT_W'(RELOAD_CYCLES - 1);
            end
         end
         imu_regs_pkg::ST_CAL: begin
            if (cnt == '0) begin
               cmd_clear[imu_regs_pkg::CMD_CAL] = 1'b1;
               next_state = imu_regs_pkg::ST_IDLE;
            end
         end
         imu_regs_pkg::ST_BIAS: begin
            if (cnt == '0) begin
               cmd_clear[imu_regs_pkg::CMD_BIAS] = 1'b1;
               next_state = imu_regs_pkg::ST_IDLE;
            end
         end
         imu_regs_pkg::ST_FLASH: begin
            if (cnt == '0) begin
               cmd_clear[imu_regs_pkg::CMD_FLASH] = 1'b1;
               next_state = imu_regs_pkg::ST_RELOAD;
               next_cnt = imu_regs_pkg::CNT_W'(RELOAD_CYCLES - 1);
            end
         end
         imu_regs_pkg::ST_RELOAD: begin
            if (cnt == '0) begin
               next_state = imu_regs_pkg::ST_IDLE;
            end
         end
         default: begin
            next_state = imu_regs_pkg::ST_IDLE;
         end
      endcase
      // A bit written in the cycle it is cleared stays set.
      next_pend = (pend & ~cmd_clear) | cmd_set;
      next_activity.soft_reset = (next_state == imu_regs_pkg::ST_RESET);
      next_activity.cal_restore = (next_state == imu_regs_pkg::ST_CAL);
      next_activity.bias_correct = (next_state == imu_regs_pkg::ST_BIAS);
      next_activity.flash_backup = (next_state == imu_regs_pkg::ST_FLASH);
      next_activity.config_reload = (next_state == imu_regs_pkg::ST_RELOAD);
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state <= imu_regs_pkg::ST_IDLE;
         cnt <= '0;
         pend <= imu_regs_pkg::CMD_RESET_VALUE;
         outs <= '0;
         reply <= imu_regs_pkg::WORD_ZERO;
         activity <= '0;
         sample_strobe <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         pend <= next_pend;
         outs <= next_outs;
         reply <= next_reply;
         activity <= next_activity;
         sample_strobe <= next_strobe;
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   AST_RATE_Y_ADDR: assert property (
      frame_read && word_addr == imu_regs_pkg::ADDR_RATE_Y |=> reply == $past(outs.rate_y))
      else $error("Rate y word not returned at its address.");

   AST_ACCEL_Z_ADDR: assert property (
      frame_read && word_addr == imu_regs_pkg::ADDR_ACCEL_Z |=> reply == $past(outs.accel_z))
      else $error("Acceleration z word not returned at its address.");

   AST_TEMP_WORD: assert property (
      frame_read && word_addr == imu_regs_pkg::ADDR_TEMPERATURE
      |=> reply[15:12] == 4'h0 && reply[11:0] == $past(outs.temperature))
      else $error("Temperature word wrong or upper bits not zero.");

   AST_CMD_WRITE_ONLY: assert property (
      frame_read && word_addr == imu_regs_pkg::ADDR_SYSTEM_COMMAND |=> reply == 16'h0000)
      else $error("Command register did not read as zero.");

   AST_PRODUCT: assert property (
      frame_read && word_addr == imu_regs_pkg::ADDR_PRODUCT_CODE |=> reply == PRODUCT_CODE)
      else $error("Product code not returned.");

   AST_SERIAL: assert property (
      frame_read && word_addr == imu_regs_pkg::ADDR_UNIT_SERIAL
      |=> reply == {4'h0, UNIT_SERIAL})
      else $error("Serial word wrong or reserved bits set.");

   AST_CAL_SELF_CLEAR: assert property (
      state == imu_regs_pkg::ST_CAL && cnt == '0 && !cmd_set[imu_regs_pkg::CMD_CAL]
      |=> !pend[imu_regs_pkg::CMD_CAL] && state == imu_regs_pkg::ST_IDLE)
      else $error("Calibration bit did not clear on completion.");

   AST_RESET_LAUNCH: assert property (
      frame_write && frame_addr == imu_regs_pkg::ADDR_SYSTEM_COMMAND && frame_word[7]
      && state == imu_regs_pkg::ST_IDLE && pend == 8'h00
      |=> ##1 state == imu_regs_pkg::ST_RESET && activity.soft_reset)
      else $error("Software reset not started two cycles after its write.");

   AST_FLASH_LAST: assert property (
      state == imu_regs_pkg::ST_IDLE && pend[imu_regs_pkg::CMD_FLASH]
      && (pend[imu_regs_pkg::CMD_CAL] || pend[imu_regs_pkg::CMD_BIAS])
      |=> state != imu_regs_pkg::ST_FLASH)
      else $error("Flash backup ran ahead of calibration or bias work.");

   AST_RELOAD_AFTER_FLASH: assert property (
      $fell(activity.flash_backup) |-> activity.config_reload && !sample_strobe)
      else $error("Flash backup not followed by configuration reload.");

   AST_ATOMIC_UPDATE: assert property (
      sample_strobe |-> outs == $past(sensor_data) && $past(state) == imu_regs_pkg::ST_IDLE)
      else $error("Sample update did not load the whole frame at once.");

   AST_NO_STRAY_UPDATE: assert property (
      !$stable(outs) && $past(state) == imu_regs_pkg::ST_IDLE |-> sample_strobe)
      else $error("Output words changed outside a sample update.");

   AST_FLASH_LAUNCH: assert property (
      state == imu_regs_pkg::ST_IDLE && pend[imu_regs_pkg::CMD_FLASH]
      && !pend[imu_regs_pkg::CMD_RESET] && !pend[imu_regs_pkg::CMD_CAL]
      && !pend[imu_regs_pkg::CMD_BIAS]
      |=> state == imu_regs_pkg::ST_FLASH && activity.flash_backup)
      else $error("Flash backup not started from a pending request.");

   AST_UNUSED_CMD_BITS: assert property (
      pend[6:4] == 3'h0 && !pend[2])
      else $error("Command bit without a function was latched.");

   AST_NO_SAMPLE_WHILE_BUSY: assert property (
      busy |=> !sample_strobe)
      else $error("Sample update during a command sequence.");

   AST_RO_WRITE_IGNORED: assert property (
      frame_write && frame_addr != imu_regs_pkg::ADDR_SYSTEM_COMMAND
      && state == imu_regs_pkg::ST_IDLE |=> pend == $past(pend))
      else $error("Write to a read-only address changed command state.");

   AST_ODD_ADDR: assert property (
      frame_read && frame_addr == 7'h05 |=> reply == $past(outs.rate_x))
      else $error("High byte address did not return the whole word.");

   AST_LOT_HIGH: assert property (
      frame_read && word_addr == imu_regs_pkg::ADDR_LOT_CODE_HIGH |=> reply == LOT_CODE_HIGH)
      else $error("Upper lot word not returned.");

endmodule : imu_output_and_command_registers
`default_nettype wire

// File: testbench/spi_host_model.sv
// Serial host model that runs mode 3 word frames against the register port.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model #(
   parameter int HALF = 8
) (
   // Clock.
   input wire logic clock,
   // Serial pins.
   output var logic sclk,
   output var logic cs_n,
   output var logic mosi,
   input wire logic miso
);
   initial begin
      sclk = 1'b1;
      cs_n = 1'b1;
      mosi = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : wait_clk
   // Sends one word MSB first and returns the word seen on miso.
   task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
      cs_n = 1'b0;
      wait_clk(HALF);
      for (int i = 15; i >= 0; i--) begin
         sclk = 1'b0;
         mosi = tx[i];
         wait_clk(HALF);
         sclk = 1'b1;
         rx[i] = miso;
         wait_clk(HALF);
      end
      cs_n = 1'b1;
      mosi = ~mosi;
      wait_clk(HALF);
   endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// File: testbench/tb_top.sv
// Self-checking bench of the IMU register bank.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int SMP = 50;
   // Identification values below are arbitrary and equal to the block's defaults.
   localparam logic [15:0] PROD = 16'h5A17;
   localparam logic [15:0] LOT_LO = 16'h1357;
   localparam logic [15:0] LOT_HI = 16'h2468;
   localparam logic [11:0] SER = 12'h001;
   typedef struct {logic [6:0] a; logic [15:0] v;} rd_row_t;
   typedef struct {logic [15:0] w; int b1; int n1; int b2; int n2;} cmd_row_t;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic sclk, cs_n, mosi, miso, sample_strobe;
   imu_regs_pkg::sensor_frame_t sensor_data;
   imu_regs_pkg::cmd_activity_t activity;
   int num_errors = 0;
   int checks_done = 0;
   int n;
   logic [15:0] rx;
   rd_row_t rows [14] = '{
      '{7'h04, 16'h61A8},
      '{7'h06, 16'hFFFF},
      '{7'h08, 16'h9E58},
      '{7'h0A, 16'h4E20},
      '{7'h0C, 16'hFFFE},
      '{7'h0E, 16'hB1E0},
      '{7'h18, 16'h0C3E},
      '{7'h3E, 16'h0000},
      '{7'h52, LOT_LO},
      '{7'h54, LOT_HI},
      '{7'h56, PROD},
      '{7'h58, {4'h0, SER}},
      '{7'h05, 16'h61A8},
      '{7'h20, 16'h0000}};
   cmd_row_t cmds [6] = '{
      '{16'hBE01, 2, 8, -1, 0},
      '{16'hBE02, 3, 8, -1, 0},
      '{16'hBE74, 2, 0, -1, 0},
      '{16'hBE80, 4, imu_regs_pkg::SOFT_RESET_CYCLES, 0, 6},
      '{16'hBE08, 1, 40, 0, 6},
      '{16'hBE09, 2, 8, 1, 40}};
   always #12.5 clock = ~clock;
   imu_output_and_command_registers #(
      .SAMPLE_CYCLES(SMP), .FLASH_CYCLES(40), .CAL_CYCLES(8),
      .BIAS_CYCLES(8), .RELOAD_CYCLES(6)
   ) imu_output_and_command_registers_i (
      .clock(clock), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
      .sensor_data(sensor_data), .activity(activity), .sample_strobe(sample_strobe)
   );
   spi_host_model spi_host_model_i (
      .clock(clock), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso)
   );
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Waits for one activity level and measures how long it stands.
   task automatic measure(input int b, input int len_exp);
      int t = 0;
      int len = 0;
      int st = 0;
      while (activity[b] !== 1'b1 && t < 400) begin
         spi_host_model_i.wait_clk(1);
         t++;
      end
      while (activity[b] === 1'b1 && len < len_exp + 20) begin
         st += (sample_strobe === 1'b1);
         spi_host_model_i.wait_clk(1);
         len++;
      end
      check(16'(len), 16'(len_exp));
      check(16'(st), 16'h0000);
   endtask : measure
   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_of_test
   initial begin
      repeat (40000) @(posedge clock);
      num_errors++;
      end_of_test();
   end
   initial begin
      sensor_data = '{16'h61A8, 16'hFFFF, 16'h9E58, 16'h4E20, 16'hFFFE, 16'hB1E0, 12'hC3E};
      repeat (16) @(posedge clock);
      #1;
      nrst = 1'b1;
      check(16'(activity), 16'h0000);
      n = 0;
      while (sample_strobe !== 1'b1 && n < 200) begin
         spi_host_model_i.wait_clk(1);
         n++;
      end
      check(16'(n), 16'(SMP + 1));
      $display("Test reset done");
      spi_host_model_i.xfer({1'b0, rows[0].a, 8'h00}, rx);
      for (int i = 1; i <= 14; i++) begin
         spi_host_model_i.xfer((i < 14) ? {1'b0, rows[i % 14].a, 8'h00} : 16'h0000, rx);
         check(rx, rows[i - 1].v);
      end
      $display("Test register reads done");
      spi_host_model_i.xfer({1'b1, 7'h56, 8'hFF}, rx);
      spi_host_model_i.xfer({1'b1, 7'h18, 8'h00}, rx);
      spi_host_model_i.xfer(16'h5600, rx);
      spi_host_model_i.xfer(16'h1800, rx);
      check(rx, PROD);
      spi_host_model_i.xfer(16'h0000, rx);
      check(rx, 16'h0C3E);
      $display("Test read-only writes done");
      sensor_data = '{16'h0001, 16'h0000, 16'hFFFE, 16'h0002, 16'h0000, 16'hFFFF, 12'h3EA};
      for (int k = 0; k < 2; k++) begin
         n = 0;
         do begin
            spi_host_model_i.wait_clk(1);
            n++;
         end while (sample_strobe !== 1'b1 && n < 2 * SMP);
      end
      check(16'(n), 16'(SMP));
      spi_host_model_i.xfer(16'h0400, rx);
      spi_host_model_i.xfer(16'h0E00, rx);
      check(rx, 16'h0001);
      spi_host_model_i.xfer(16'h1800, rx);
      check(rx, 16'hFFFF);
      spi_host_model_i.xfer(16'h0000, rx);
      check(rx, 16'h03EA);
      $display("Test sample refresh done");
      for (int i = 0; i < 6; i++) begin
         // The command starts while its frame is still closing, so timing runs alongside it.
         fork
            spi_host_model_i.xfer(cmds[i].w, rx);
            begin
               measure(cmds[i].b1, cmds[i].n1);
               if (cmds[i].b2 >= 0) begin
                  measure(cmds[i].b2, cmds[i].n2);
               end
            end
         join
         spi_host_model_i.wait_clk(100);
         check(16'(activity), 16'h0000);
         $display("Test command %h done", cmds[i].w);
      end
      spi_host_model_i.xfer(16'hBE08, rx);
      check(16'(activity.flash_backup), 16'h0001);
      nrst = 1'b0;
      spi_host_model_i.wait_clk(2);
      check(16'({activity, sample_strobe}), 16'h0000);
      nrst = 1'b1;
      spi_host_model_i.wait_clk(100);
      check(16'(activity), 16'h0000);
      $display("Test reset during flash done");
      end_of_test();
   end
endmodule : tb_top
`default_nettype wire
